// file: verilog/nand_parity_config.sv
// Flash parity generators, configuration register and AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module nand_parity_config
	import nand_parity_pkg::*;
#(
	parameter int MAIN_BYTES  = MAIN_BYTES_DOC,
	parameter int SPARE_BYTES = SPARE_BYTES_DOC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        data_valid,
	input  wire logic [15:0] data_word,
	input  wire logic        data_spare,
	input  wire logic        auto_load_active,
	input  wire logic        auto_store_active,
	input  wire logic        boot_load_active,
	input  wire logic        hw_select_n,
	input  wire logic        manual_select_n,
	input  wire logic        large_page_sense,
	input  wire logic        wide_memory_sense,
	input  wire logic        bus_width_sense,
	input  wire logic        page_size_sense,
	input  wire logic        address_cycle_sense,
	input  wire logic        ready_busy_lane0,
	input  wire logic        second_ready_busy_input,
	input  wire logic        flash_is_boot,
	output logic             flash_chip_select_n,
	output logic             flash_ready,
	output logic [6:0]       select_high_hold_cycles,
	output logic [2:0]       latch_strobe_cycles,
	output logic [3:0]       strobe_active_cycles,
	output logic [3:0]       strobe_recovery_cycles,
	output logic             wide_memory_flag,
	output logic             large_page_flag,
	output logic             bus_width_16,
	output logic             page_size_large,
	output logic             address_cycle_extra
);
	localparam int MAIN_IDX_W  = $clog2(MAIN_BYTES);
	localparam int SPARE_IDX_W = $clog2(SPARE_BYTES);

	if (MAIN_BYTES < 2 || MAIN_BYTES > MAIN_BYTES_DOC || (MAIN_BYTES & (MAIN_BYTES - 1)) != 0)
		$error("MAIN_BYTES must be a power of two up to 2048");
	if (SPARE_BYTES < 2 || SPARE_BYTES > SPARE_BYTES_DOC
			|| (SPARE_BYTES & (SPARE_BYTES - 1)) != 0)
		$error("SPARE_BYTES must be a power of two up to 16");

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_e;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} rd_state_e;

	// Column parity of one byte, unprimed bits for weights 1, 2, 4
	function automatic logic [COL_W-1:0] col_true(input logic [7:0] d);
		logic [COL_W-1:0] c;
		c = '0;
		for (int b = 0; b < 8; b++) begin
			for (int k = 0; k < COL_W; k++) begin
				if (b[k])
					c[k] = c[k] ^ d[b];
			end
		end
		return c;
	endfunction : col_true

	function automatic logic [COL_W-1:0] col_comp(input logic [7:0] d);
		logic [COL_W-1:0] c;
		c = '0;
		for (int b = 0; b < 8; b++) begin
			for (int k = 0; k < COL_W; k++) begin
				if (!b[k])
					c[k] = c[k] ^ d[b];
			end
		end
		return c;
	endfunction : col_comp

	function automatic logic [1:0] pair(input logic t, input logic c);
		return {t, c};
	endfunction : pair

	// Main parity word: byte3..byte0
	function automatic logic [31:0] pack_main(
		input logic [MAIN_LINE_W-1:0] lt, input logic [MAIN_LINE_W-1:0] lc,
		input logic [COL_W-1:0] ct, input logic [COL_W-1:0] cc);
		logic [31:0] w;
		w = '0;
		w[7:0]   = {pair(lt[3], lc[3]), pair(lt[2], lc[2]), pair(lt[1], lc[1]),
			pair(lt[0], lc[0])};
		w[15:8]  = {pair(lt[7], lc[7]), pair(lt[6], lc[6]), pair(lt[5], lc[5]),
			pair(lt[4], lc[4])};
		w[23:16] = {pair(ct[2], cc[2]), pair(ct[1], cc[1]), pair(ct[0], cc[0]),
			pair(lt[8], lc[8])};
		w[31:24] = {pair(lt[10], lc[10]), pair(lt[9], lc[9]), 4'h0};
		return w;
	endfunction : pack_main

	// Spare parity half word: byte1, byte0
	function automatic logic [15:0] pack_spare(
		input logic [SPARE_LINE_W-1:0] lt, input logic [SPARE_LINE_W-1:0] lc,
		input logic [COL_W-1:0] ct, input logic [COL_W-1:0] cc);
		logic [15:0] w;
		w = '0;
		w[7:0]  = {pair(lt[1], lc[1]), pair(lt[0], lc[0]), pair(ct[2], cc[2]),
			pair(ct[1], cc[1])};
		w[15:8] = {pair(ct[0], cc[0]), pair(lt[3], lc[3]), pair(lt[2], lc[2]), 2'h0};
		return w;
	endfunction : pack_spare

	// Pin synchroniser
	logic [PIN_W-1:0] pin_meta_reg;
	logic [PIN_W-1:0] pin_sync_reg;
	logic [PIN_W-1:0] pins;
	assign pins = {flash_is_boot, second_ready_busy_input, ready_busy_lane0,
		address_cycle_sense, page_size_sense, bus_width_sense, wide_memory_sense,
		large_page_sense};

	// Free running so the straps have settled by the time reset lifts
	always_ff @(posedge aclk) begin
		pin_meta_reg <= pins;
		pin_sync_reg <= pin_meta_reg;
	end

	// Sensed geometry, caught once after reset release
	logic sensed_reg;
	logic large_reg;
	logic wide_reg;
	logic width_reg;
	logic page_reg;
	logic acyc_reg;
	logic sense_delay_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sense_delay_reg <= 1'b0;
			sensed_reg      <= 1'b0;
			large_reg       <= 1'b0;
			wide_reg        <= 1'b0;
			width_reg       <= 1'b0;
			page_reg        <= 1'b0;
			acyc_reg        <= 1'b0;
		end else begin
			sense_delay_reg <= 1'b1;
			if (sense_delay_reg && !sensed_reg) begin
				sensed_reg <= 1'b1;
				large_reg  <= pin_sync_reg[PIN_LARGE];
				wide_reg   <= pin_sync_reg[PIN_WIDE];
				width_reg  <= pin_sync_reg[PIN_WIDTH];
				page_reg   <= pin_sync_reg[PIN_PAGE];
				acyc_reg   <= pin_sync_reg[PIN_ACYC];
			end
		end
	end

	// Software registers
	logic [5:0] select_high_hold_time_reg;
	logic [2:0] latch_strobe_time_reg;
	logic [2:0] act_reg;
	logic [2:0] rec_reg;
	logic       hwcs_reg;
	logic       main_parity_hold;
	logic       spare_parity_hold;
	logic       parity_clear;

	// AXI write channel
	wr_state_e   wr_state_reg;
	logic        aw_have_reg;
	logic        w_have_reg;
	logic [31:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_fire;
	logic        wr_hit;

	assign s_axi_awready = wr_state_reg == WR_IDLE && !aw_have_reg;
	assign s_axi_wready  = wr_state_reg == WR_IDLE && !w_have_reg;
	assign wr_fire = wr_state_reg == WR_IDLE && aw_have_reg && w_have_reg;
	assign wr_hit  = aw_addr_reg == ADDR_CONFIG || aw_addr_reg == ADDR_CONTROL;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_reg <= WR_IDLE;
			aw_have_reg  <= 1'b0;
			w_have_reg   <= 1'b0;
			aw_addr_reg  <= '0;
			w_data_reg   <= '0;
			w_strb_reg   <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			case (wr_state_reg)
				WR_IDLE: begin
					if (s_axi_awvalid && s_axi_awready) begin
						aw_have_reg <= 1'b1;
						aw_addr_reg <= {s_axi_awaddr[31:2], 2'h0};
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_have_reg <= 1'b1;
						w_data_reg <= s_axi_wdata;
						w_strb_reg <= s_axi_wstrb;
					end
					if (wr_fire) begin
						aw_have_reg  <= 1'b0;
						w_have_reg   <= 1'b0;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
						wr_state_reg <= WR_RESP;
					end
				end
				WR_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						wr_state_reg <= WR_IDLE;
					end
				end
				default: wr_state_reg <= WR_IDLE;
			endcase
		end
	end

	// Register writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			select_high_hold_time_reg          <= SELECT_HIGH_HOLD_TIME_RST;
			latch_strobe_time_reg         <= LATCH_STROBE_TIME_RST;
			act_reg           <= ACT_RST;
			rec_reg           <= REC_RST;
			hwcs_reg          <= HWCS_RST;
			main_parity_hold  <= HOLD_RST;
			spare_parity_hold <= HOLD_RST;
			parity_clear      <= 1'b0;
		end else begin
			parity_clear <= 1'b0;
			if (wr_fire && aw_addr_reg == ADDR_CONFIG) begin
				if (w_strb_reg[0]) begin
					rec_reg  <= w_data_reg[CFG_REC_LSB +: 3];
					hwcs_reg <= w_data_reg[CFG_HWCS_BIT];
				end
				if (w_strb_reg[1]) begin
					act_reg   <= w_data_reg[CFG_ACT_LSB +: 3];
					latch_strobe_time_reg <= w_data_reg[CFG_LATCH_STROBE_TIME_LSB +: 3];
				end
				if (w_strb_reg[2])
					select_high_hold_time_reg <= w_data_reg[CFG_SELECT_HIGH_HOLD_TIME_LSB +: 6];
			end
			if (wr_fire && aw_addr_reg == ADDR_CONTROL && w_strb_reg[1]) begin
				main_parity_hold  <= w_data_reg[CTL_MAIN_HOLD_BIT];
				spare_parity_hold <= w_data_reg[CTL_SPARE_HOLD_BIT];
				parity_clear      <= w_data_reg[CTL_CLEAR_BIT];
			end
		end
	end

	// Parity generators
	logic [MAIN_IDX_W-1:0]   main_idx_reg;
	logic [SPARE_IDX_W-1:0]  spare_idx_reg;
	logic [MAIN_LINE_W-1:0]  main_lt_reg [LANES];
	logic [MAIN_LINE_W-1:0]  main_lc_reg [LANES];
	logic [SPARE_LINE_W-1:0] spare_lt_reg [LANES];
	logic [SPARE_LINE_W-1:0] spare_lc_reg [LANES];
	logic [COL_W-1:0]        main_ct_reg [LANES];
	logic [COL_W-1:0]        main_cc_reg [LANES];
	logic [COL_W-1:0]        spare_ct_reg [LANES];
	logic [COL_W-1:0]        spare_cc_reg [LANES];
	logic                    auto_mode;
	logic                    main_update;
	logic                    spare_update;
	logic [LANES-1:0]        lane_on;

	assign auto_mode    = auto_load_active || auto_store_active;
	assign main_update  = data_valid && !data_spare
		&& (auto_mode || !main_parity_hold);
	assign spare_update = data_valid && data_spare && !auto_mode
		&& !spare_parity_hold;
	assign lane_on      = {width_reg, 1'b1};

	always_ff @(posedge aclk) begin
		if (!aresetn || parity_clear) begin
			main_idx_reg  <= '0;
			spare_idx_reg <= '0;
		end else begin
			if (main_update)
				main_idx_reg <= main_idx_reg == MAIN_IDX_W'(MAIN_BYTES - 1)
					? '0 : main_idx_reg + 1'b1;
			if (spare_update)
				spare_idx_reg <= spare_idx_reg == SPARE_IDX_W'(SPARE_BYTES - 1)
					? '0 : spare_idx_reg + 1'b1;
		end
	end

	for (genvar g = 0; g < LANES; g++) begin : g_lane
		logic [7:0] lane_byte;
		logic       byte_par;
		assign lane_byte = data_word[8*g +: 8];
		assign byte_par  = ^lane_byte;

		always_ff @(posedge aclk) begin
			if (!aresetn || parity_clear) begin
				main_lt_reg[g]  <= '0;
				main_lc_reg[g]  <= '0;
				main_ct_reg[g]  <= '0;
				main_cc_reg[g]  <= '0;
				spare_lt_reg[g] <= '0;
				spare_lc_reg[g] <= '0;
				spare_ct_reg[g] <= '0;
				spare_cc_reg[g] <= '0;
			end else begin
				if (main_update && lane_on[g]) begin
					for (int k = 0; k < MAIN_LINE_W; k++) begin
						if (k < MAIN_IDX_W && main_idx_reg[k % MAIN_IDX_W])
							main_lt_reg[g][k] <= main_lt_reg[g][k] ^ byte_par;
						else
							main_lc_reg[g][k] <= main_lc_reg[g][k] ^ byte_par;
					end
					main_ct_reg[g] <= main_ct_reg[g] ^ col_true(lane_byte);
					main_cc_reg[g] <= main_cc_reg[g] ^ col_comp(lane_byte);
				end
				if (spare_update && lane_on[g]) begin
					for (int k = 0; k < SPARE_LINE_W; k++) begin
						if (k < SPARE_IDX_W && spare_idx_reg[k % SPARE_IDX_W])
							spare_lt_reg[g][k] <= spare_lt_reg[g][k] ^ byte_par;
						else
							spare_lc_reg[g][k] <= spare_lc_reg[g][k] ^ byte_par;
					end
					spare_ct_reg[g] <= spare_ct_reg[g] ^ col_true(lane_byte);
					spare_cc_reg[g] <= spare_cc_reg[g] ^ col_comp(lane_byte);
				end
			end
		end
	end

	logic [31:0] main_word [LANES];
	logic [31:0] spare_word;
	for (genvar g = 0; g < LANES; g++) begin : g_pack
		assign main_word[g] = pack_main(main_lt_reg[g], main_lc_reg[g],
			main_ct_reg[g], main_cc_reg[g]);
	end
	assign spare_word = {pack_spare(spare_lt_reg[1], spare_lc_reg[1], spare_ct_reg[1],
		spare_cc_reg[1]), pack_spare(spare_lt_reg[0], spare_lc_reg[0], spare_ct_reg[0],
		spare_cc_reg[0])};

	// Configuration readback
	logic [31:0] config_word;
	always_comb begin
		config_word = '0;
		config_word[CFG_LARGE_BIT]         = large_reg;
		config_word[CFG_SELECT_HIGH_HOLD_TIME_LSB +: 6]     = select_high_hold_time_reg;
		config_word[CFG_LATCH_STROBE_TIME_LSB +: 3]    = latch_strobe_time_reg;
		config_word[CFG_ACT_LSB +: 3]      = act_reg;
		config_word[CFG_WIDE_BIT]          = wide_reg;
		config_word[CFG_REC_LSB +: 3]      = rec_reg;
		config_word[CFG_HWCS_BIT]          = hwcs_reg;
		config_word[CFG_WIDTH_BIT]         = width_reg;
		config_word[CFG_PAGE_BIT]          = page_reg;
		config_word[CFG_ACYC_BIT]          = acyc_reg;
	end

	// AXI read channel
	rd_state_e rd_state_reg;
	assign s_axi_arready = rd_state_reg == RD_IDLE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_reg <= RD_IDLE;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else begin
			case (rd_state_reg)
				RD_IDLE: begin
					if (s_axi_arvalid) begin
						s_axi_rvalid <= 1'b1;
						s_axi_rresp  <= RESP_OKAY;
						rd_state_reg <= RD_DATA;
						case ({s_axi_araddr[31:2], 2'h0})
							ADDR_CONFIG:     s_axi_rdata <= config_word;
							ADDR_CONTROL:    s_axi_rdata <= {21'h0, spare_parity_hold,
								main_parity_hold, 9'h0};
							ADDR_MAIN_LANE0: s_axi_rdata <= main_word[0];
							ADDR_MAIN_LANE1: s_axi_rdata <= main_word[1];
							ADDR_SPARE:      s_axi_rdata <= spare_word;
							default: begin
								s_axi_rdata <= '0;
								s_axi_rresp <= RESP_SLVERR;
							end
						endcase
					end
				end
				RD_DATA: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_state_reg <= RD_IDLE;
					end
				end
				default: rd_state_reg <= RD_IDLE;
			endcase
		end
	end

	// Timing and pin outputs
	logic second_rb_eff;
	assign second_rb_eff = pin_sync_reg[PIN_BOOT] ? pin_sync_reg[PIN_RB1] : 1'b1;
	assign flash_ready = pin_sync_reg[PIN_RB0] && (!width_reg || second_rb_eff);
	assign flash_chip_select_n = hwcs_reg ? hw_select_n : manual_select_n;
	assign select_high_hold_cycles = (boot_load_active || auto_load_active)
		? 7'(select_high_hold_time_reg) + 7'h1 : 7'h0;
	assign latch_strobe_cycles    = latch_strobe_time_reg;
	assign strobe_active_cycles   = 4'(act_reg) + 4'h1;
	assign strobe_recovery_cycles = 4'(rec_reg) + 4'h1;
	assign wide_memory_flag    = wide_reg;
	assign large_page_flag     = large_reg;
	assign bus_width_16        = width_reg;
	assign page_size_large     = page_reg;
	assign address_cycle_extra = acyc_reg;

	// Checks
	a_main_hold_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
		main_parity_hold && !auto_mode && !parity_clear |=> $stable(main_word[0]))
		else $error("main parity changed while held");
	a_store_no_spare: assert property (@(posedge aclk) disable iff (!aresetn)
		auto_store_active && !parity_clear |=> $stable(spare_word))
		else $error("spare parity changed during auto store");
	a_clear_zeroes: assert property (@(posedge aclk) disable iff (!aresetn)
		parity_clear |=> main_word[0] == 32'h0 && spare_word == 32'h0)
		else $error("parity not cleared");
	a_main_low_nibble: assert property (@(posedge aclk) disable iff (!aresetn)
		main_word[1][27:24] == 4'h0) else $error("main byte3 low nibble not zero");
	a_spare_low_bits: assert property (@(posedge aclk) disable iff (!aresetn)
		spare_word[9:8] == 2'h0) else $error("spare byte1 low bits not zero");
	a_auto_updates: assert property (@(posedge aclk) disable iff (!aresetn)
		data_valid && !data_spare && auto_mode && !parity_clear && ^data_word[7:0]
		|=> main_word[0] != $past(main_word[0]))
		else $error("auto mode did not update parity");
	a_active_width: assert property (@(posedge aclk) disable iff (!aresetn)
		strobe_active_cycles == 4'(config_word[CFG_ACT_LSB +: 3]) + 4'h1
		&& strobe_recovery_cycles == 4'(config_word[CFG_REC_LSB +: 3]) + 4'h1)
		else $error("strobe width wrong");
	a_hold_time_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!boot_load_active && !auto_load_active |-> select_high_hold_cycles == 7'h0)
		else $error("select hold applied outside load");
	a_select_manual: assert property (@(posedge aclk) disable iff (!aresetn)
		!hwcs_reg |-> flash_chip_select_n == manual_select_n)
		else $error("chip select not manual");
	a_second_rb_high: assert property (@(posedge aclk) disable iff (!aresetn)
		!pin_sync_reg[PIN_BOOT] && width_reg |-> flash_ready == pin_sync_reg[PIN_RB0])
		else $error("second ready busy not held high");
endmodule : nand_parity_config
`default_nettype wire

// file: common/nand_parity_pkg.sv
// Constants for the flash parity and configuration block
package nand_parity_pkg;
	localparam logic [31:0] ADDR_CONFIG     = 32'h40c00000;
	localparam logic [31:0] ADDR_CONTROL    = 32'h40c00004;
	localparam logic [31:0] ADDR_MAIN_LANE0 = 32'h40c00030;
	localparam logic [31:0] ADDR_MAIN_LANE1 = 32'h40c00034;
	localparam logic [31:0] ADDR_SPARE      = 32'h40c00038;

	localparam int CFG_LARGE_BIT = 22;
	localparam int CFG_SELECT_HIGH_HOLD_TIME_LSB  = 16;
	localparam int CFG_LATCH_STROBE_TIME_LSB = 12;
	localparam int CFG_ACT_LSB   = 8;
	localparam int CFG_WIDE_BIT  = 7;
	localparam int CFG_REC_LSB   = 4;
	localparam int CFG_HWCS_BIT  = 3;
	localparam int CFG_WIDTH_BIT = 2;
	localparam int CFG_PAGE_BIT  = 1;
	localparam int CFG_ACYC_BIT  = 0;

	localparam int CTL_CLEAR_BIT      = 8;
	localparam int CTL_MAIN_HOLD_BIT  = 9;
	localparam int CTL_SPARE_HOLD_BIT = 10;

	localparam logic [5:0] SELECT_HIGH_HOLD_TIME_RST  = 6'h3f;
	localparam logic [2:0] LATCH_STROBE_TIME_RST = 3'h1;
	localparam logic [2:0] ACT_RST   = 3'h6;
	localparam logic [2:0] REC_RST   = 3'h6;
	localparam logic       HWCS_RST  = 1'b1;
	localparam logic       HOLD_RST  = 1'b1;

	localparam int MAIN_BYTES_DOC  = 2048;
	localparam int SPARE_BYTES_DOC = 16;
	localparam int MAIN_LINE_W     = 11;
	localparam int SPARE_LINE_W    = 4;
	localparam int COL_W           = 3;
	localparam int LANES           = 2;

	// Sense, ready/busy and boot pin positions in the synchronised pin vector
	localparam int PIN_LARGE = 0;
	localparam int PIN_WIDE  = 1;
	localparam int PIN_WIDTH = 2;
	localparam int PIN_PAGE  = 3;
	localparam int PIN_ACYC  = 4;
	localparam int PIN_RB0   = 5;
	localparam int PIN_RB1   = 6;
	localparam int PIN_BOOT  = 7;
	localparam int PIN_W     = 8;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : nand_parity_pkg

// file: testbench/flash_model.sv
// Flash memory stand-in returning data words and ready/busy pins
`timescale 1ns/1ps
`default_nettype none
module flash_model (
	input  wire logic        aclk,
	input  wire logic        send,
	input  wire logic        send_spare,
	input  wire logic [15:0] send_word,
	output logic             data_valid,
	output logic             data_spare,
	output logic [15:0]      data_word,
	output logic             ready_busy_lane0,
	output logic             second_ready_busy_input
);
	logic [1:0] busy_reg = 2'h0;
	initial data_valid = 1'b0;
	initial data_spare = 1'b0;
	initial data_word = 16'h0;
	// Tied low, so it reads busy once flash_is_boot selects it as ready/busy
	assign second_ready_busy_input = 1'b0;
	assign ready_busy_lane0 = (busy_reg == 2'h0);
	always @(posedge aclk) begin
		data_valid <= send;
		data_spare <= send_spare;
		// Released bus inverts every bit of its previous value on each idle cycle
		data_word <= send ? send_word : ~data_word;
		busy_reg <= send ? 2'h2 : busy_reg - {1'b0, |busy_reg};
	end
endmodule : flash_model
`default_nettype wire

// file: testbench/test_nand_parity_config.sv
// Self-checking bench for the flash parity and configuration block
`timescale 1ns/1ps
`default_nettype none
module test_nand_parity_config;
	import nand_parity_pkg::*;
	localparam int MB = 16;
	localparam int SB = 4;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, r, sb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  s_axi_awprot, s_axi_arprot, latch_strobe_cycles;
	logic [3:0]  s_axi_wstrb, strobe_active_cycles, strobe_recovery_cycles;
	logic [6:0]  select_high_hold_cycles;
	logic [15:0] data_word, send_word;
	logic [4:0]  sv;
	logic data_valid, data_spare, auto_load_active, auto_store_active, boot_load_active;
	logic hw_select_n, manual_select_n, ready_busy_lane0, second_ready_busy_input, send;
	logic flash_is_boot, flash_chip_select_n, flash_ready, wide_memory_flag, large_page_flag;
	logic bus_width_16, page_size_large, address_cycle_extra, send_spare;
	logic large_page_sense, wide_memory_sense, bus_width_sense, page_size_sense;
	logic address_cycle_sense;
	logic [1:0]  lp [2][2][11];
	logic [1:0]  cp [2][2][3];
	logic [33:0] expq [$];
	int num_errors = 0, check_count = 0, seed = 32'hff3d, cyc = 0, idx [2];

	nand_parity_config #(.MAIN_BYTES(MB), .SPARE_BYTES(SB)) DUT (.*);
	flash_model partner (.*);

	always #50 aclk = ~aclk;

	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			conclude();
		end
	end

	// Read data and write responses are compared in arrival order against the noted values
	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			chk("read", {s_axi_rresp, s_axi_rdata}, expq.pop_front());
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			chk("write", {s_axi_bresp, 32'h0}, expq.pop_front());
	end

	task automatic xfer(input bit rdn, input logic [31:0] a, d, input logic [33:0] e);
		logic aw, w, ar, b;
		expq.push_back(e);
		if (rdn) begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end else begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end
		do begin
			@(negedge aclk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			ar = s_axi_arvalid & s_axi_arready;
			b = rdn ? s_axi_rvalid & s_axi_rready : s_axi_bvalid & s_axi_bready;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (ar) s_axi_arvalid <= 1'b0;
			if (b) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
			end
		end while (!b);
		@(posedge aclk);
	endtask : xfer

	task automatic acc(input int ar, input logic [15:0] wd);
		for (int l = 0; l < 2; l++)
			for (int k = 0; k < 11; k++) begin
				if (k < 3)
					for (int j = 0; j < 8; j++) cp[ar][l][k][j >> k & 1] ^= wd[8*l+j];
				lp[ar][l][k][idx[ar] >> k & 1] ^= ^wd[8*l+:8];
			end
		idx[ar] = (idx[ar] + 1) % (ar ? SB : MB);
	endtask : acc

	task automatic words(input int n, input bit me, input bit se);
		logic sp;
		logic [15:0] wd;
		repeat (n) begin
			sp = $random(seed);
			wd = $random(seed);
			send <= 1'b1;
			send_spare <= sp;
			send_word <= wd;
			if (sp ? se : me) acc(sp, wd);
			@(posedge aclk);
		end
		send <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask : words

	function automatic logic [31:0] mpk(input int l);
		return {lp[0][l][10], lp[0][l][9], 4'h0, cp[0][l][2], cp[0][l][1], cp[0][l][0],
			lp[0][l][8], lp[0][l][7], lp[0][l][6], lp[0][l][5], lp[0][l][4],
			lp[0][l][3], lp[0][l][2], lp[0][l][1], lp[0][l][0]};
	endfunction : mpk

	function automatic logic [15:0] spk(input int l);
		return {cp[1][l][0], lp[1][l][3], lp[1][l][2], 2'h0,
			lp[1][l][1], lp[1][l][0], cp[1][l][2], cp[1][l][1]};
	endfunction : spk

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
		{send, send_spare, send_word, flash_is_boot} = '0;
		{auto_load_active, auto_store_active, boot_load_active} = '0;
		s_axi_wstrb = 4'hf;
		sv = $random(seed);
		sv[2] = 1'b1;
		{large_page_sense, wide_memory_sense, bus_width_sense, page_size_sense} = sv[4:1];
		address_cycle_sense = sv[0];
		sb = {9'h0, sv[4], 14'h0, sv[3], 4'h0, sv[2:0]};
		hw_select_n = $random(seed);
		manual_select_n = !hw_select_n;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		xfer(1, ADDR_CONFIG, 0, {RESP_OKAY, 32'h003f1668 | sb});
		xfer(1, ADDR_CONTROL, 0, {RESP_OKAY, 32'h600});
		xfer(1, ADDR_CONFIG + 32'h100, 0, {RESP_SLVERR, 32'h0});
		xfer(0, ADDR_CONFIG + 32'h100, 32'hffffffff, {RESP_SLVERR, 32'h0});
		chk("straps", {large_page_flag, wide_memory_flag, bus_width_16, page_size_large,
			address_cycle_extra}, sv);
		r = $random(seed);
		xfer(0, ADDR_CONFIG, r, 0);
		boot_load_active <= 1'b1;
		xfer(1, ADDR_CONFIG, 0, {RESP_OKAY, r & 32'h003f7778 | sb});
		chk("timing", {latch_strobe_cycles, strobe_active_cycles, strobe_recovery_cycles,
			select_high_hold_cycles}, {r[14:12], r[10:8] + 4'h1, r[6:4] + 4'h1,
			r[21:16] + 7'h1});
		chk("select", flash_chip_select_n, r[3] ? hw_select_n : manual_select_n);
		boot_load_active <= 1'b0;
		for (int m = 0; m < 3; m++) begin
			xfer(0, ADDR_CONTROL, m ? 32'h700 : 32'h100, 0);
			lp = '{default: '0};
			cp = '{default: '0};
			idx = '{0, 0};
			repeat (2) @(posedge aclk);
			auto_store_active <= (m == 1);
			auto_load_active <= (m == 2);
			words(20, 1, m == 0);
			if (m == 0) xfer(0, ADDR_CONTROL, 32'h600, 0);
			if (m == 0) words(6, 0, 0);
			auto_store_active <= 1'b0;
			auto_load_active <= 1'b0;
			xfer(1, ADDR_MAIN_LANE0, 0, {RESP_OKAY, mpk(0)});
			xfer(1, ADDR_MAIN_LANE1, 0, {RESP_OKAY, mpk(1)});
			xfer(1, ADDR_SPARE, 0, {RESP_OKAY, spk(1), spk(0)});
		end
		@(negedge aclk);
		chk("ready", flash_ready, 1'b1);
		@(posedge aclk);
		flash_is_boot <= 1'b1;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk("boot ready", flash_ready, 1'b0);
		conclude();
	end
endmodule : test_nand_parity_config
`default_nettype wire
